/* File: src/pd_controller_end.sv */
// controller-side command issue and CKE gating for power-down
// Functional notes
// - enter power-down: CKE low with NOP
// - CKE high during MRS, MPR, ZQ, read, write
// - CKE may drop during activate, precharge, refresh
// - one clock after ACT/PRE/REF; MRS waits mode delay
// - read: RL plus 4 plus 1
// - write: WL plus 4 plus write recovery
// - fixed chop four saves two clocks
// - write autoclose: WL plus 4 plus WR plus 1
// - exit latency before refresh, long delay before reentry
// - slow exit makes termination asynchronous
// - entry disables buffers except clock, ODT, CKE, reset
// - only NOP/DES until buffer-disable delay
// - unlocked DLL at entry needs reset after exit
// - open bank gives active power-down
// - mode bit picks DLL off or on
// - hold CKE low, reset high, ODT valid
// - reset low leaves power-down
// - minimum and maximum power-down time
// - exit CKE high with NOP, hold tCKE
// - exit latency before any valid command
// - slow exit: DLL latency before read/termination
// - illegal self refresh temperature combination refused
`timescale 1ns/1ns
`default_nettype none
module pd_controller_end (
  input  wire logic       ref_clk,       // system clock
  input  wire logic       reset_n,       // async reset
  pd_link_if.ctrl         link,          // memory link
  input  wire logic       reqValid,      // user command request
  input  wire logic [3:0] reqCmd,        // user command code
  input  wire logic       reqOdt,        // user wants termination
  input  wire logic       pdReq,         // request power-down
  input  wire logic       wakeReq,       // request exit
  input  wire logic       memReset,      // request memory reset
  input  wire logic [7:0] readLat,       // read latency clocks
  input  wire logic [7:0] writeLat,      // write latency clocks
  input  wire logic [7:0] writeRec,      // write recovery clocks
  input  wire logic       fixedBc4,      // fixed_burst_chop_four setting
  input  wire logic       slowExit,      // precharge pd slow exit mode
  input  wire logic       dllLocked,     // dll believed locked
  input  wire logic       autoSrRate,    // auto_selfrefresh_rate bit
  input  wire logic       extTempSr,     // extended_temp_selfrefresh bit
  output logic            reqReady,      // request accepted
  output logic            inPowerDown,   // in power-down
  output logic            dllResetNeed,  // dll must be reset
  output logic            srCfgBad,      // temperature bits illegal
  output logic            pdOverrun      // power-down max exceeded
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    S_RUN  = 2'b00,
    S_PD   = 2'b01,
    S_WAKE = 2'b10
  } st_e;
  typedef struct packed {
    st_e        st;
    logic       cke;
    logic [3:0] cmd;
    logic       odt;
    logic       rst;
    logic [7:0] entryWait;  // clocks until CKE may fall
    logic [7:0] minHold;    // CKE low/high minimum
    logic [7:0] exitWait;   // exit latency
    logic [7:0] dllWait;    // dll exit latency
    logic [7:0] reentry;    // xpdll wait after refresh
    logic [7:0] cpded;
    logic [31:0] pdCnt;
    logic       refSinceExit;
    logic       slowPd;
    logic       dllBad;
    logic       ready;
    logic       cfgBad;
    logic       overrun;
  } st_s;
  st_s cur_q, nxt_d;

  function automatic logic [7:0] maxOf(input logic [7:0] a, input logic [7:0] b);
    maxOf = (a > b) ? a : b;
  endfunction : maxOf

  function automatic logic [7:0] dec(input logic [7:0] v);
    dec = (v != 8'h00) ? v - 8'h01 : 8'h00;
  endfunction : dec

  function automatic logic [7:0] entryDelay(input logic [3:0] c, input logic [7:0] rl,
      input logic [7:0] wl, input logic [7:0] wr, input logic bc4);
    logic [7:0] half;
    half = bc4 ? pd_pkg::BC4_SAVE : pd_pkg::BURST_HALF;
    case (c)
      pd_pkg::CMD_ACT:  entryDelay = pd_pkg::T_ACTPDEN;
      pd_pkg::CMD_PRE:  entryDelay = pd_pkg::T_PRPDEN;
      pd_pkg::CMD_REF:  entryDelay = pd_pkg::T_REFPDEN;
      pd_pkg::CMD_MRS:  entryDelay = pd_pkg::T_MOD;
      pd_pkg::CMD_RD,
      pd_pkg::CMD_RD_CLOSE: entryDelay = rl + pd_pkg::BURST_HALF + pd_pkg::ONE_CK;
      pd_pkg::CMD_WR:   entryDelay = wl + half + wr;
      pd_pkg::CMD_WRAP: entryDelay = wl + half + wr + pd_pkg::ONE_CK;
      pd_pkg::CMD_ZQ,
      pd_pkg::CMD_MPR:  entryDelay = pd_pkg::T_MOD;
      default:          entryDelay = 8'h00;
    endcase
  endfunction : entryDelay

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    logic cmdOk;
    logic isDll;
    cmdOk = 1'b0;
    isDll = 1'b0;
    nxt_d = cur_q;
    nxt_d.cmd       = pd_pkg::CMD_NOP;
    nxt_d.ready     = 1'b0;
    nxt_d.entryWait = dec(cur_q.entryWait);
    nxt_d.minHold   = dec(cur_q.minHold);
    nxt_d.exitWait  = dec(cur_q.exitWait);
    nxt_d.dllWait   = dec(cur_q.dllWait);
    nxt_d.reentry   = dec(cur_q.reentry);
    nxt_d.cpded     = dec(cur_q.cpded);
    nxt_d.cfgBad    = autoSrRate & extTempSr;
    nxt_d.rst       = ~memReset;
    isDll = (reqCmd == pd_pkg::CMD_RD) || (reqCmd == pd_pkg::CMD_RD_CLOSE);
    if (memReset) begin
      nxt_d.st  = S_RUN;
      nxt_d.cke = 1'b0;
      nxt_d.odt = 1'b0;
    end else begin
      case (cur_q.st)
        S_RUN: begin
          nxt_d.cke = 1'b1;
          nxt_d.odt = reqOdt & (cur_q.dllWait == 8'h00) & ~cur_q.dllBad;
          cmdOk = reqValid && cur_q.exitWait == 8'h00 && cur_q.minHold == 8'h00
                  && !(isDll && (cur_q.dllWait != 8'h00 || cur_q.dllBad))
                  && !(reqCmd == pd_pkg::CMD_MRS && cur_q.cfgBad);
          if (cmdOk) begin
            nxt_d.cmd       = reqCmd;
            nxt_d.ready     = 1'b1;
            nxt_d.entryWait = maxOf(dec(cur_q.entryWait),
                                    entryDelay(reqCmd, readLat, writeLat, writeRec, fixedBc4));
            if (reqCmd == pd_pkg::CMD_REF && cur_q.refSinceExit)
              nxt_d.reentry = pd_pkg::T_XPDLL;
            if (reqCmd == pd_pkg::CMD_MRS) nxt_d.dllBad = 1'b0;
          end else if (pdReq && cur_q.entryWait == 8'h00 && cur_q.reentry == 8'h00
                       && cur_q.minHold == 8'h00 && cur_q.exitWait == 8'h00) begin
            nxt_d.cke     = 1'b0;
            nxt_d.odt     = 1'b0;
            nxt_d.st      = S_PD;
            nxt_d.minHold = pd_pkg::T_PDMIN;
            nxt_d.cpded   = pd_pkg::T_CPDED;
            nxt_d.pdCnt   = 32'h0000_0000;
            nxt_d.slowPd  = slowExit;
            nxt_d.dllBad  = cur_q.dllBad | ~dllLocked;
          end
        end
        S_PD: begin
          nxt_d.cke   = 1'b0;
          nxt_d.pdCnt = cur_q.pdCnt + 32'h0000_0001;
          if (cur_q.pdCnt >= 32'(pd_pkg::PD_MAX_CK)) nxt_d.overrun = 1'b1;
          if ((wakeReq || cur_q.pdCnt >= 32'(pd_pkg::PD_MAX_CK))
              && cur_q.minHold == 8'h00 && cur_q.cpded == 8'h00) begin
            nxt_d.cke          = 1'b1;
            nxt_d.st           = S_WAKE;
            nxt_d.minHold      = pd_pkg::T_CKE;
            nxt_d.exitWait     = pd_pkg::T_XP;
            nxt_d.dllWait      = cur_q.slowPd ? pd_pkg::T_XPDLL : 8'h00;
            nxt_d.refSinceExit = 1'b1;
          end
        end
        S_WAKE: begin
          nxt_d.cke = 1'b1;
          nxt_d.st  = S_RUN;
        end
        default: nxt_d.st = S_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_q <= '0;
      cur_q.st <= S_RUN;
      cur_q.cmd <= pd_pkg::CMD_NOP;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link.cke     = cur_q.cke;
  assign link.cmd     = cur_q.cmd;
  assign link.odt     = cur_q.odt;
  assign link.resetN  = cur_q.rst;
  assign reqReady     = cur_q.ready;
  assign inPowerDown  = (cur_q.st == S_PD);
  assign dllResetNeed = cur_q.dllBad;
  assign srCfgBad     = cur_q.cfgBad;
  assign pdOverrun    = cur_q.overrun;
endmodule : pd_controller_end
`default_nettype wire

/* File: common/pd_pkg.sv */
// shared constants and types for power-down sequencing
package pd_pkg;
  // command codes on the link
  localparam logic [3:0] CMD_NOP      = 4'h0;
  localparam logic [3:0] CMD_DES      = 4'h1;
  localparam logic [3:0] CMD_ACT      = 4'h2;
  localparam logic [3:0] CMD_PRE      = 4'h3;
  localparam logic [3:0] CMD_REF      = 4'h4;
  localparam logic [3:0] CMD_MRS      = 4'h5;
  localparam logic [3:0] CMD_RD       = 4'h6;
  localparam logic [3:0] CMD_RD_CLOSE = 4'h7;
  localparam logic [3:0] CMD_WR       = 4'h8;
  localparam logic [3:0] CMD_WRAP     = 4'h9;
  localparam logic [3:0] CMD_ZQ       = 4'hA;
  localparam logic [3:0] CMD_MPR      = 4'hB;

  localparam int CLK_PS = 8000;
  // timings in clocks, except XPDLL_NS in ns
  localparam logic [7:0] T_ACTPDEN  = 8'h01;
  localparam logic [7:0] T_PRPDEN   = 8'h01;
  localparam logic [7:0] T_REFPDEN  = 8'h01;
  localparam logic [7:0] T_MOD      = 8'h0C;
  localparam logic [7:0] BURST_HALF = 8'h04;
  localparam logic [7:0] BC4_SAVE   = 8'h02;
  localparam logic [7:0] ONE_CK     = 8'h01;
  localparam int XPDLL_MIN_CK = 10;
  localparam int XPDLL_NS     = 24;
  localparam int XPDLL_NS_CK  = (XPDLL_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [7:0] T_XPDLL =
    8'((XPDLL_NS_CK > XPDLL_MIN_CK) ? XPDLL_NS_CK : XPDLL_MIN_CK);
  localparam logic [7:0] T_XP     = 8'h03;
  localparam logic [7:0] T_CPDED  = 8'h01;
  localparam logic [7:0] T_PDMIN  = 8'h03;
  localparam logic [7:0] T_CKE    = 8'h03;
  localparam logic [7:0] T_ANPD   = 8'h01;
  // power-down upper bound: 9 refresh intervals of 7.8us
  localparam int TREFI_NS     = 7800;
  localparam int PD_MAX_CK    = 9 * TREFI_NS * 1000 / CLK_PS;

  typedef enum logic [2:0] {
    PD_NONE     = 3'b000,
    PD_ACTIVE   = 3'b001,
    PD_PRE_FAST = 3'b010,
    PD_PRE_SLOW = 3'b011,
    PD_RESET    = 3'b100
  } pd_mode_e;
endpackage : pd_pkg

/* File: common/pd_link_if.sv */
// link between controller and memory power-down logic
`timescale 1ns/1ns
`default_nettype none
interface pd_link_if;
  logic       cke;
  logic [3:0] cmd;
  logic       odt;
  logic       resetN;
  modport ctrl (output cke, output cmd, output odt, output resetN);
  modport mem  (input cke, input cmd, input odt, input resetN);
endinterface : pd_link_if
`default_nettype wire

/* File: src/pd_memory_end.sv */
// memory-side power-down state keeping
`timescale 1ns/1ns
`default_nettype none
module pd_memory_end (
  input  wire logic      ref_clk,       // system clock
  input  wire logic      reset_n,       // async reset
  pd_link_if.mem         link,          // controller link
  input  wire logic      fastExit,      // mode bit: 1 fast exit
  output logic     [2:0] pdMode,        // current power-down mode
  output logic           dllOn,         // dll running
  output logic           buffersOn,     // io buffers enabled
  output logic           odtAsync,      // termination asynchronous
  output logic     [7:0] openBanks      // bank open flags
);
  typedef struct packed {
    pd_pkg::pd_mode_e mode;
    logic             dll;
    logic             buf_;
    logic             async;
    logic [7:0]       banks;
    logic [7:0]       cnt;
  } st_s;
  st_s cur_q, nxt_d;

  function automatic logic isIdleCmd(input logic [3:0] c);
    isIdleCmd = (c == pd_pkg::CMD_NOP) || (c == pd_pkg::CMD_DES);
  endfunction : isIdleCmd

  always_comb begin
    nxt_d = cur_q;
    if (cur_q.cnt != 8'h00) nxt_d.cnt = cur_q.cnt - 8'h01;
    if (cur_q.async && cur_q.mode == pd_pkg::PD_NONE && cur_q.cnt == 8'h00)
      nxt_d.async = 1'b0;
    if (!link.resetN) begin
      nxt_d.mode  = pd_pkg::PD_RESET;
      nxt_d.banks = 8'h00;
      nxt_d.buf_  = 1'b0;
      nxt_d.dll   = 1'b0;
    end else if (cur_q.mode == pd_pkg::PD_RESET) begin
      nxt_d.mode = pd_pkg::PD_NONE;
      nxt_d.buf_ = 1'b1;
      nxt_d.dll  = 1'b1;
    end else if (cur_q.mode == pd_pkg::PD_NONE) begin
      if (link.cmd == pd_pkg::CMD_ACT) nxt_d.banks = cur_q.banks | 8'h01;
      if (link.cmd == pd_pkg::CMD_PRE || link.cmd == pd_pkg::CMD_RD_CLOSE
          || link.cmd == pd_pkg::CMD_WRAP) nxt_d.banks = 8'h00;
      if (!link.cke && isIdleCmd(link.cmd)) begin
        nxt_d.buf_ = 1'b0;
        if (cur_q.banks != 8'h00) begin
          nxt_d.mode = pd_pkg::PD_ACTIVE;
        end else if (fastExit) begin
          nxt_d.mode = pd_pkg::PD_PRE_FAST;
        end else begin
          nxt_d.mode  = pd_pkg::PD_PRE_SLOW;
          nxt_d.dll   = 1'b0;
          nxt_d.async = 1'b1;
        end
      end
    end else if (link.cke && isIdleCmd(link.cmd)) begin
      nxt_d.mode = pd_pkg::PD_NONE;
      nxt_d.buf_ = 1'b1;
      nxt_d.dll  = 1'b1;
      if (cur_q.mode == pd_pkg::PD_PRE_SLOW)
        nxt_d.cnt = 8'(pd_pkg::T_ANPD + pd_pkg::T_XPDLL);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_q <= '{mode: pd_pkg::PD_NONE, dll: 1'b1, buf_: 1'b1, async: 1'b0,
                 banks: 8'h00, cnt: 8'h00};
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign pdMode    = cur_q.mode;
  assign dllOn     = cur_q.dll;
  assign buffersOn = cur_q.buf_;
  assign odtAsync  = cur_q.async;
  assign openBanks = cur_q.banks;
endmodule : pd_memory_end
`default_nettype wire

/* File: verification/pd_link_props.sv */
// assertions on the power-down link between the two ends
`timescale 1ns/1ns
`default_nettype none
module pd_link_props (
  input wire logic       ref_clk,  // system clock
  input wire logic       reset_n,  // async reset
  input wire logic       cke,      // clock enable
  input wire logic [3:0] cmd,      // command code
  input wire logic       odt,      // termination request
  input wire logic       resetN,   // memory reset
  input wire logic [7:0] readLat,  // read latency
  input wire logic [7:0] writeLat, // write latency
  input wire logic [7:0] writeRec, // write recovery
  input wire logic       fixedBc4  // fixed chop four
);
  logic [7:0] gap_q;
  logic [7:0] need_q;
  logic [7:0] exitGap_q;
  logic       inPd_q;
  logic       refSeen_q;
  logic       idleCmd;
  assign idleCmd = (cmd == pd_pkg::CMD_NOP) || (cmd == pd_pkg::CMD_DES);
  // minimum clocks from a command to a sampled-low cke
  function automatic logic [7:0] entryNeed(input logic [3:0] c);
    case (c)
      pd_pkg::CMD_RD, pd_pkg::CMD_RD_CLOSE: entryNeed = readLat + 8'h05;
      pd_pkg::CMD_WR: entryNeed = writeLat + writeRec + (fixedBc4 ? 8'h02 : 8'h04);
      pd_pkg::CMD_WRAP: entryNeed = writeLat + writeRec + (fixedBc4 ? 8'h03 : 8'h05);
      pd_pkg::CMD_MRS, pd_pkg::CMD_ZQ, pd_pkg::CMD_MPR: entryNeed = pd_pkg::T_MOD;
      default: entryNeed = 8'h01;
    endcase
  endfunction : entryNeed
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_q <= 8'hFF;
      need_q <= 8'h00;
      exitGap_q <= 8'hFF;
      inPd_q <= 1'b0;
      refSeen_q <= 1'b0;
    end else begin
      if (!idleCmd) begin
        gap_q <= 8'h01;
        need_q <= entryNeed(cmd);
      end else if (gap_q != 8'hFF) begin
        gap_q <= gap_q + 8'h01;
      end
      inPd_q <= $fell(cke) ? 1'b1 : (cke ? 1'b0 : inPd_q);
      if (cke && inPd_q) begin
        exitGap_q <= 8'h01;
      end else if (exitGap_q != 8'hFF) begin
        exitGap_q <= exitGap_q + 8'h01;
      end
      refSeen_q <= $fell(cke) ? 1'b0 : (refSeen_q || (cmd == pd_pkg::CMD_REF
                   && exitGap_q != 8'hFF));
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_entry_idle: assert property ($fell(cke) |-> idleCmd)
    else $error("cke fell without idle command");
  chk_exit_idle: assert property ($rose(cke) |-> idleCmd)
    else $error("cke rose without idle command");
  chk_pd_min: assert property ($fell(cke) |=> !cke [*2])
    else $error("power-down shorter than minimum");
  chk_cke_hold: assert property ($rose(cke) |=> cke [*2])
    else $error("cke high pulse too short");
  chk_pd_quiet: assert property ((!cke && inPd_q) |-> idleCmd)
    else $error("command during power-down");
  chk_entry_gap: assert property ($fell(cke) |-> gap_q >= need_q)
    else $error("entry too soon after command");
  chk_exit_wait: assert property (!idleCmd |-> exitGap_q >= pd_pkg::T_XP)
    else $error("command too soon after exit");
  chk_refresh_gap: assert property ($fell(cke) && refSeen_q |-> exitGap_q >= pd_pkg::T_XPDLL)
    else $error("reentry too soon after refresh");
  chk_pd_odt_off: assert property ((!cke && inPd_q) |-> !odt)
    else $error("termination on during power-down");
  chk_reset_cke: assert property (!resetN |-> !cke)
    else $error("cke high while memory reset");
  cover property ($fell(cke));
  cover property ($rose(cke) && inPd_q);
  cover property ($fell(cke) && refSeen_q);
endmodule : pd_link_props
`default_nettype wire

/* File: verification/dram_power_down_control_tb.sv */
// self-checking bench joining controller and memory ends
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    nFail++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module dram_power_down_control_tb;
  logic       ref_clk, reset_n, reqValid, reqOdt, pdReq, wakeReq, memReset, fixedBc4;
  logic       slowExit, fastExit, dllLocked, autoSrRate, extTempSr, reqReady, inPowerDown;
  logic       dllResetNeed, srCfgBad, pdOverrun, dllOn, buffersOn, odtAsync;
  logic [3:0] reqCmd;
  logic [7:0] readLat, writeLat, writeRec, openBanks;
  logic [2:0] pdMode;
  int         nFail, checked, cnt;
  logic [3:0] seq [12] = '{pd_pkg::CMD_ACT, pd_pkg::CMD_RD, pd_pkg::CMD_WR, pd_pkg::CMD_WR,
    pd_pkg::CMD_WRAP, pd_pkg::CMD_ACT, pd_pkg::CMD_RD_CLOSE, pd_pkg::CMD_PRE, pd_pkg::CMD_REF,
    pd_pkg::CMD_MRS, pd_pkg::CMD_ZQ, pd_pkg::CMD_MPR};
  logic [11:0] bc4 = 12'h018;
  logic [11:0] opn = 12'h02F;
  assign fastExit = !slowExit;
  pd_link_if link ();
  pd_controller_end i_pd_controller_end (.ref_clk(ref_clk), .reset_n(reset_n), .link(link),
    .reqValid(reqValid), .reqCmd(reqCmd), .reqOdt(reqOdt), .pdReq(pdReq), .wakeReq(wakeReq),
    .memReset(memReset), .readLat(readLat), .writeLat(writeLat), .writeRec(writeRec),
    .fixedBc4(fixedBc4), .slowExit(slowExit), .dllLocked(dllLocked), .autoSrRate(autoSrRate),
    .extTempSr(extTempSr), .reqReady(reqReady), .inPowerDown(inPowerDown),
    .dllResetNeed(dllResetNeed), .srCfgBad(srCfgBad), .pdOverrun(pdOverrun));
  pd_memory_end i_pd_memory_end (.ref_clk(ref_clk), .reset_n(reset_n), .link(link),
    .fastExit(fastExit), .pdMode(pdMode), .dllOn(dllOn), .buffersOn(buffersOn),
    .odtAsync(odtAsync), .openBanks(openBanks));
  pd_link_props i_pd_link_props (.ref_clk(ref_clk), .reset_n(reset_n), .cke(link.cke),
    .cmd(link.cmd), .odt(link.odt), .resetN(link.resetN), .readLat(readLat),
    .writeLat(writeLat), .writeRec(writeRec), .fixedBc4(fixedBc4));
  always #4 ref_clk = ~ref_clk;
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  function automatic int need(input logic [3:0] c, input logic b);
    case (c)
      pd_pkg::CMD_RD, pd_pkg::CMD_RD_CLOSE: need = int'(readLat) + 4 + 1;
      pd_pkg::CMD_WR: need = int'(writeLat) + int'(writeRec) + (b ? 2 : 4);
      pd_pkg::CMD_WRAP: need = int'(writeLat) + int'(writeRec) + (b ? 2 : 4) + 1;
      pd_pkg::CMD_MRS, pd_pkg::CMD_ZQ, pd_pkg::CMD_MPR: need = 12;
      default: need = 1;
    endcase
  endfunction : need
  // one-cycle request, repeated while refused
  task automatic issue(input logic [3:0] c);
    int tries;
    tries = 0;
    do begin
      @(posedge ref_clk);
      reqValid <= 1'b1;
      reqCmd <= c;
      @(posedge ref_clk);
      reqValid <= 1'b0;
      #1;
      tries++;
    end while (reqReady !== 1'b1 && tries < 40);
    `CHK(link.cmd, c)
  endtask : issue
  // count clocks from pdReq rise to cke low
  task automatic enter(output int n);
    @(posedge ref_clk);
    pdReq <= 1'b1;
    n = 1;
    #1;
    while (link.cke !== 1'b0 && n < 80) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : enter
  task automatic leave();
    int n;
    @(posedge ref_clk);
    pdReq <= 1'b0;
    wakeReq <= 1'b1;
    n = 0;
    #1;
    while (link.cke !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    wakeReq <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : leave
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrapUp
  initial begin
    #200000;
    nFail++;
    wrapUp();
  end
  initial begin
    {reqValid, reqOdt, pdReq, wakeReq, memReset, fixedBc4, slowExit} = 7'h00;
    {autoSrRate, extTempSr, reset_n, ref_clk} = 4'h0;
    dllLocked = 1'b1;
    reqCmd = pd_pkg::CMD_NOP;
    readLat = 8'h05;
    writeLat = 8'h05;
    writeRec = 8'h06;
    nFail = 0;
    checked = 0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK(link.resetN, 1'b1)
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk);
      fixedBc4 <= bc4[i];
      issue(seq[i]);
      enter(cnt);
      `CHK(cnt >= need(seq[i], bc4[i]), 1'b1)
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(pdMode, opn[i] ? pd_pkg::PD_ACTIVE : pd_pkg::PD_PRE_FAST)
      `CHK(buffersOn, 1'b0)
      `CHK(inPowerDown, 1'b1)
      `CHK(openBanks[0], opn[i])
      leave();
    end
    @(posedge ref_clk);
    slowExit <= 1'b1;
    dllLocked <= 1'b0;
    enter(cnt);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(pdMode, pd_pkg::PD_PRE_SLOW)
    `CHK(dllOn, 1'b0)
    `CHK(odtAsync, 1'b1)
    leave();
    `CHK(odtAsync, 1'b1)
    `CHK(dllResetNeed, 1'b1)
    @(posedge ref_clk);
    reqOdt <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(link.odt, 1'b0)
    repeat (9) @(posedge ref_clk);
    #1;
    `CHK(odtAsync, 1'b0)
    @(posedge ref_clk);
    slowExit <= 1'b0;
    dllLocked <= 1'b1;
    enter(cnt);
    leave();
    issue(pd_pkg::CMD_REF);
    enter(cnt);
    `CHK(link.cke, 1'b0)
    leave();
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      {autoSrRate, extTempSr} <= 2'(i);
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK(srCfgBad, i == 3)
    end
    enter(cnt);
    repeat (3) @(posedge ref_clk);
    memReset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK(link.resetN, 1'b0)
    `CHK(pdMode, pd_pkg::PD_RESET)
    `CHK(pdOverrun, 1'b0)
    wrapUp();
  end
endmodule : dram_power_down_control_tb
`default_nettype wire
